// >>> rtl/tcr_defs.svh
// Purpose: offsets, field positions and reset values of the timer regs
// Assumes: 6-bit byte address on the 8-bit I/O register port
// Notes: each unit owns a 16-byte window, unit select is address bit 4
`ifndef TCR_DEFS_SVH
`define TCR_DEFS_SVH

// byte offsets inside one unit window; bit 0 picks low (0) or high (1)
`define TCR_OFS_CNT 4'h0
`define TCR_OFS_CMP_A 4'h2
`define TCR_OFS_CMP_B 4'h4
`define TCR_OFS_CMP_C 4'h6
`define TCR_OFS_CAP 4'h8
`define TCR_UNIT_BIT 4
`define TCR_ADDR_MASK 6'h20

// interrupt mask field positions for the first unit
`define TCR_MASK_CAPTURE 5
`define TCR_MASK_CMP_A 4
`define TCR_MASK_CMP_B 3
`define TCR_MASK_OVERFLOW 2

`define TCR_RST_WORD 16'h0000
`define TCR_RST_BYTE 8'h00

`endif

// >>> rtl/tcr_pkg.sv
// Purpose: shared types of the timer register block
// Assumes: offsets live in tcr_defs.svh
// Notes: field code equals address bits 3:1 inside a unit window
package tcr_pkg;
    typedef enum logic [2:0] {
        TCR_F_CNT = 3'b000,
        TCR_F_CMP_A = 3'b001,
        TCR_F_CMP_B = 3'b010,
        TCR_F_CMP_C = 3'b011,
        TCR_F_CAP = 3'b100
    } tcr_field_type;
    typedef logic [15:0] tcr_word_type;
    typedef logic [7:0] tcr_byte_type;
endpackage

// >>> rtl/tcr_regs.sv
// Purpose: counter, compare and capture values of two 16-bit timer units
// Assumes: core_clk 20 MHz; timer_tick is a one-cycle enable per unit
// Notes: all 16-bit writes, and counter and capture reads, move through one shared high-byte latch
`include "tcr_defs.svh"

module tcr_regs #(
    parameter int UNITS = 2,
    parameter int CHANNELS = 3
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [5:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire tcr_pkg::tcr_byte_type io_wdata,
    output tcr_pkg::tcr_byte_type io_rdata,
    input wire logic [UNITS-1:0] timer_tick,
    input wire logic [UNITS-1:0] top_from_capture,
    input wire logic [UNITS-1:0] capture_input_pin,
    input wire logic [UNITS-1:0] capture_edge_polarity,
    input wire logic capture_from_comparator,
    input wire logic comparator_out,
    input wire logic global_irq_enable,
    input wire logic [3:0] timer1_flags,
    output tcr_pkg::tcr_word_type counter_value_t1,
    output tcr_pkg::tcr_word_type counter_value_t3,
    output logic [UNITS*CHANNELS-1:0] compare_match,
    output logic [UNITS*CHANNELS-1:0] compare_output_pin,
    output logic [UNITS-1:0] capture_event,
    output logic [3:0] timer1_irq_req
);
    import tcr_pkg::*;

    logic rst_meta_q;
    logic rst_sync_n;
    tcr_word_type cnt_q [UNITS];
    tcr_word_type cmp_q [UNITS][CHANNELS];
    tcr_word_type cap_q [UNITS];
    tcr_byte_type temp_q;
    tcr_byte_type mask_q;
    logic [UNITS-1:0] blk_q;
    logic [UNITS-1:0] pin_q;
    logic [UNITS*CHANNELS-1:0] pend_q;
    logic [UNITS*CHANNELS-1:0] match_now;
    logic [UNITS-1:0] cap_src;
    logic [UNITS-1:0] cap_edge;
    logic [UNITS-1:0] cnt_wr;
    logic unit_sel;
    logic hi_sel;
    logic in_unit;
    logic mask_sel;
    tcr_field_type fld;
    logic [1:0] cmp_idx;
    // reset released through two flops, asserted at once
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_n <= rst_meta_q;
        end
    end

    assign unit_sel = io_addr[`TCR_UNIT_BIT];
    assign hi_sel = io_addr[0];
    assign in_unit = !io_addr[5] && (io_addr[3:1] <= 3'(TCR_F_CAP));
    assign mask_sel = (io_addr == `TCR_ADDR_MASK);
    assign fld = tcr_field_type'(io_addr[3:1]);
    assign cmp_idx = io_addr[2:1] - 2'd1;
    // low-byte write completes the counter load
    always_comb begin
        cnt_wr = '0;
        if (io_wr && in_unit && !hi_sel && fld == TCR_F_CNT) begin
            cnt_wr[unit_sel] = 1'b1;
        end
    end
    // shared high-byte latch: high write parks, low read fills
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            temp_q <= `TCR_RST_BYTE;
        end else if (io_wr && in_unit && hi_sel) begin
            temp_q <= io_wdata;
        end else if (io_rd && in_unit && !hi_sel) begin
            unique case (fld)
                TCR_F_CNT: temp_q <= cnt_q[unit_sel][15:8];
                TCR_F_CAP: temp_q <= cap_q[unit_sel][15:8];
                default: temp_q <= cmp_q[unit_sel][cmp_idx][15:8];
            endcase
        end
    end
    // read data; counter and capture high bytes come from the latch
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            io_rdata <= `TCR_RST_BYTE;
        end else if (io_rd && mask_sel) begin
            io_rdata <= mask_q;
        end else if (io_rd && in_unit) begin
            unique case (fld)
                TCR_F_CNT: io_rdata <= hi_sel ? temp_q
                    : cnt_q[unit_sel][7:0];
                TCR_F_CAP: io_rdata <= hi_sel ? temp_q
                    : cap_q[unit_sel][7:0];
                default: io_rdata <= hi_sel
                    ? cmp_q[unit_sel][cmp_idx][15:8]
                    : cmp_q[unit_sel][cmp_idx][7:0];
            endcase
        end else if (io_rd) begin
            io_rdata <= `TCR_RST_BYTE;
        end
    end
    // counters: cpu load wins over a tick in the same cycle
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            for (int u = 0; u < UNITS; u++) begin
                cnt_q[u] <= `TCR_RST_WORD;
            end
        end else begin
            for (int u = 0; u < UNITS; u++) begin
                if (cnt_wr[u]) begin
                    cnt_q[u] <= {temp_q, io_wdata};
                end else if (timer_tick[u]) begin
                    if (top_from_capture[u] && cnt_q[u] == cap_q[u]) begin
                        cnt_q[u] <= `TCR_RST_WORD;
                    end else begin
                        cnt_q[u] <= cnt_q[u] + 16'h0001;
                    end
                end
            end
        end
    end
    // match blocking: a load may jump onto a compare value, so the
    // next tick would fire a spurious match; software still risks
    // skipping past a compare it meant to hit
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            blk_q <= '0;
        end else begin
            for (int u = 0; u < UNITS; u++) begin
                if (cnt_wr[u]) begin
                    blk_q[u] <= 1'b1;
                end else if (timer_tick[u]) begin
                    blk_q[u] <= 1'b0;
                end
            end
        end
    end
    // compare values take both bytes on the low write
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            for (int u = 0; u < UNITS; u++) begin
                for (int c = 0; c < CHANNELS; c++) begin
                    cmp_q[u][c] <= `TCR_RST_WORD;
                end
            end
        end else if (io_wr && in_unit && !hi_sel && fld != TCR_F_CNT
                && fld != TCR_F_CAP) begin
            cmp_q[unit_sel][cmp_idx] <= {temp_q, io_wdata};
        end
    end
    always_comb begin
        for (int u = 0; u < UNITS; u++) begin
            for (int c = 0; c < CHANNELS; c++) begin
                match_now[u*CHANNELS+c] = timer_tick[u] && !blk_q[u]
                    && cnt_q[u] == cmp_q[u][c];
            end
        end
    end
    // match is held and reported on the following tick
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pend_q <= '0;
            compare_match <= '0;
            compare_output_pin <= '0;
        end else begin
            for (int u = 0; u < UNITS; u++) begin
                for (int c = 0; c < CHANNELS; c++) begin
                    if (timer_tick[u]) begin
                        pend_q[u*CHANNELS+c] <= match_now[u*CHANNELS+c];
                        compare_match[u*CHANNELS+c] <=
                            pend_q[u*CHANNELS+c];
                        if (pend_q[u*CHANNELS+c]) begin
                            compare_output_pin[u*CHANNELS+c] <=
                                !compare_output_pin[u*CHANNELS+c];
                        end
                    end else begin
                        compare_match[u*CHANNELS+c] <= 1'b0;
                    end
                end
            end
        end
    end
    // capture source and edge; off while the value is used as TOP
    always_comb begin
        cap_src = capture_input_pin;
        cap_src[0] = capture_from_comparator ? comparator_out
            : capture_input_pin[0];
        for (int u = 0; u < UNITS; u++) begin
            cap_edge[u] = !top_from_capture[u] && (capture_edge_polarity[u]
                ? (cap_src[u] && !pin_q[u])
                : (!cap_src[u] && pin_q[u]));
        end
    end

    // hardware capture wins over a cpu write in the same cycle
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pin_q <= '0;
            capture_event <= '0;
            for (int u = 0; u < UNITS; u++) begin
                cap_q[u] <= `TCR_RST_WORD;
            end
        end else begin
            pin_q <= cap_src;
            capture_event <= cap_edge;
            for (int u = 0; u < UNITS; u++) begin
                if (cap_edge[u]) begin
                    cap_q[u] <= cnt_q[u];
                end else if (io_wr && in_unit && !hi_sel
                        && fld == TCR_F_CAP && unit_sel == 1'(u)) begin
                    cap_q[u] <= {temp_q, io_wdata};
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mask_q <= `TCR_RST_BYTE;
        end else if (io_wr && mask_sel) begin
            mask_q <= io_wdata;
        end
    end

    // flag order on timer1_flags: capture, cmp A, cmp B, overflow
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            timer1_irq_req <= '0;
        end else begin
            timer1_irq_req <= {mask_q[`TCR_MASK_CAPTURE],
                mask_q[`TCR_MASK_CMP_A], mask_q[`TCR_MASK_CMP_B],
                mask_q[`TCR_MASK_OVERFLOW]} & timer1_flags
                & {4{global_irq_enable}};
        end
    end

    assign counter_value_t1 = cnt_q[0];
    assign counter_value_t3 = cnt_q[1];

    property p_cnt_load;
        @(posedge core_clk) disable iff (!rst_sync_n)
        cnt_wr[0] |=> cnt_q[0] == {$past(temp_q), $past(io_wdata)};
    endproperty
    a_cnt_load: assert property (p_cnt_load)
        else $error("counter load lost bytes");
    property p_temp_hold;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (io_wr && in_unit && hi_sel) |=> temp_q == $past(io_wdata);
    endproperty
    a_temp_hold: assert property (p_temp_hold)
        else $error("high byte not parked");
    property p_cnt_read;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (io_rd && in_unit && !hi_sel && fld == TCR_F_CNT && !unit_sel)
        |=> temp_q == $past(cnt_q[0][15:8])
            && io_rdata == $past(cnt_q[0][7:0]);
    endproperty
    a_cnt_read: assert property (p_cnt_read)
        else $error("counter read not atomic");
    property p_block;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (blk_q[0] && timer_tick[0]) |=> pend_q[CHANNELS-1:0] == '0;
    endproperty
    a_block: assert property (p_block)
        else $error("match after counter load");
    property p_match_next;
        @(posedge core_clk) disable iff (!rst_sync_n)
        match_now[0] ##1 (!timer_tick[0])[*3] ##1 timer_tick[0]
        |=> compare_match[0];
    endproperty
    a_match_next: assert property (p_match_next)
        else $error("match strobe missing");
    property p_capture;
        @(posedge core_clk) disable iff (!rst_sync_n)
        cap_edge[0] |=> cap_q[0] == $past(cnt_q[0]) && capture_event[0];
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture did not copy counter");
    property p_irq;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (global_irq_enable && mask_q[`TCR_MASK_CAPTURE] && timer1_flags[3])
        |=> timer1_irq_req[3];
    endproperty
    a_irq: assert property (p_irq)
        else $error("capture irq not raised");
    property p_no_irq;
        @(posedge core_clk) disable iff (!rst_sync_n)
        !global_irq_enable |=> timer1_irq_req == 4'h0;
    endproperty
    a_no_irq: assert property (p_no_irq)
        else $error("irq without global enable");
    property p_cmp_write;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (io_wr && in_unit && !hi_sel && fld == TCR_F_CMP_A && !unit_sel)
        |=> cmp_q[0][0] == {$past(temp_q), $past(io_wdata)};
    endproperty
    a_cmp_write: assert property (p_cmp_write)
        else $error("compare update not atomic");
    property p_edge_sense;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (!top_from_capture[1] && capture_edge_polarity[1]
            && !pin_q[1] && cap_src[1]) |=> capture_event[1];
    endproperty
    a_edge_sense: assert property (p_edge_sense)
        else $error("rising edge missed");
endmodule

// >>> dv/tcr_cpu_model.sv
// Purpose: cpu side of the 8-bit timer register port
// Assumes: strobes launched just after a rising edge
// Notes: one idle cycle between accesses keeps strobes apart
module tcr_cpu_model (
    input wire logic core_clk,
    output logic [5:0] io_addr,
    output logic io_wr,
    output logic io_rd,
    output tcr_pkg::tcr_byte_type io_wdata,
    input wire tcr_pkg::tcr_byte_type io_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import tcr_pkg::*;
    initial begin
        io_addr = 6'h00;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h00;
    end
    task automatic wr(input logic [5:0] a, input tcr_byte_type d);
        @(posedge core_clk);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(posedge core_clk);
        io_wr <= 1'b0;
        // released data must not look like the last byte
        io_wdata <= ~d;
        @(negedge core_clk);
    endtask
    task automatic rd(input logic [5:0] a, output tcr_byte_type d);
        @(posedge core_clk);
        io_addr <= a;
        io_rd <= 1'b1;
        @(posedge core_clk);
        io_rd <= 1'b0;
        @(negedge core_clk);
        d = io_rdata;
    endtask
    // high byte parks in the shared latch, low commits
    // counter writes are only made while ticks are quiet
    task automatic wr16(input logic [5:0] a, input tcr_word_type v);
        wr(a | 6'h01, v[15:8]);
        wr(a, v[7:0]);
    endtask
    // low first so the high byte comes from the same sample
    task automatic rd16(input logic [5:0] a, output tcr_word_type v);
        rd(a, v[7:0]);
        rd(a | 6'h01, v[15:8]);
    endtask
endmodule

// >>> dv/tcr_regs_tb_top.sv
// Purpose: self-checking bench of the timer register block
// Assumes: cpu model owns the bus, bench owns ticks, pins and flags
// Notes: pulses are counted on every rising edge, so no window is missed
`define CHK(got, exp) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            err_count++; \
            $display("mismatch %0t got %h exp %h", $time, got, exp); \
        end \
    end
module tcr_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import tcr_pkg::*;
    logic core_clk;
    logic rst_n;
    logic [5:0] io_addr;
    logic io_wr;
    logic io_rd;
    tcr_byte_type io_wdata;
    tcr_byte_type io_rdata;
    logic [1:0] timer_tick;
    logic [1:0] top_from_capture;
    logic [1:0] capture_input_pin;
    logic [1:0] capture_edge_polarity;
    logic capture_from_comparator;
    logic comparator_out;
    logic global_irq_enable;
    logic [3:0] timer1_flags;
    tcr_word_type counter_value_t1;
    tcr_word_type counter_value_t3;
    logic [5:0] compare_match;
    logic [5:0] compare_output_pin;
    logic [1:0] capture_event;
    logic [3:0] timer1_irq_req;
    int err_count = 0;
    int checks_done = 0;
    int match_cnt [6];
    int cap_cnt [2];
    tcr_byte_type b;
    tcr_word_type w;
    tcr_regs u_dut (
        .core_clk(core_clk), .rst_n(rst_n), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .timer_tick(timer_tick),
        .top_from_capture(top_from_capture),
        .capture_input_pin(capture_input_pin),
        .capture_edge_polarity(capture_edge_polarity),
        .capture_from_comparator(capture_from_comparator),
        .comparator_out(comparator_out),
        .global_irq_enable(global_irq_enable),
        .timer1_flags(timer1_flags),
        .counter_value_t1(counter_value_t1),
        .counter_value_t3(counter_value_t3),
        .compare_match(compare_match),
        .compare_output_pin(compare_output_pin),
        .capture_event(capture_event), .timer1_irq_req(timer1_irq_req)
    );
    tcr_cpu_model u_cpu (
        .core_clk(core_clk), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata)
    );
    always @(posedge core_clk) begin
        for (int i = 0; i < 6; i++) begin
            if (compare_match[i] === 1'b1) begin
                match_cnt[i]++;
            end
        end
        for (int i = 0; i < 2; i++) begin
            if (capture_event[i] === 1'b1) begin
                cap_cnt[i]++;
            end
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic settle();
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task automatic tick(input logic [1:0] u);
        @(posedge core_clk);
        timer_tick <= u;
        @(posedge core_clk);
        timer_tick <= 2'b00;
        settle();
    endtask
    task automatic cap_in(input logic [1:0] pol, input logic [1:0] pin,
                          input logic cmp);
        @(posedge core_clk);
        capture_edge_polarity <= pol;
        capture_input_pin <= pin;
        comparator_out <= cmp;
        settle();
    endtask
    task automatic irq_in(input logic g, input logic [3:0] f);
        @(posedge core_clk);
        global_irq_enable <= g;
        timer1_flags <= f;
        settle();
    endtask
    task automatic t_reset();
        `CHK(counter_value_t1, 16'h0000);
        for (int i = 0; i < 22; i++) begin
            u_cpu.rd(6'(i < 10 ? i : i + 6), b);
            `CHK(b, 8'h00);
        end
        u_cpu.rd(6'h20, b);
        `CHK(b, 8'h00);
        u_cpu.rd(6'h3f, b);
        `CHK(b, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_count();
        u_cpu.wr16(6'h00, 16'h1234);
        `CHK(counter_value_t1, 16'h1234);
        u_cpu.wr16(6'h10, 16'h12ff);
        u_cpu.rd16(6'h10, w);
        `CHK(w, 16'h12ff);
        u_cpu.rd(6'h10, b);
        tick(2'b10);
        `CHK(counter_value_t3, 16'h1300);
        u_cpu.rd(6'h11, b);
        `CHK(b, 8'h12);
        // compare high byte feeds the counter low write
        u_cpu.wr(6'h05, 8'hab);
        u_cpu.wr(6'h00, 8'hcd);
        `CHK(counter_value_t1, 16'habcd);
        $display("test count done");
    endtask
    task automatic t_compare();
        for (int u = 0; u < 2; u++) begin
            for (int c = 0; c < 3; c++) begin
                u_cpu.wr16(6'(u * 16 + 2 + 2 * c), 16'h0020);
            end
            u_cpu.rd16(6'(u * 16 + 4), w);
            `CHK(w, 16'h0020);
        end
        u_cpu.wr16(6'h00, 16'h0020);
        u_cpu.wr16(6'h10, 16'h0020);
        tick(2'b11);
        tick(2'b11);
        `CHK(match_cnt.sum(), 0);
        u_cpu.wr16(6'h00, 16'h001f);
        u_cpu.wr16(6'h10, 16'h001f);
        tick(2'b11);
        tick(2'b11);
        `CHK(match_cnt.sum(), 0);
        tick(2'b11);
        for (int i = 0; i < 6; i++) begin
            `CHK(match_cnt[i], 1);
        end
        `CHK(compare_output_pin, 6'h3f);
        $display("test compare done");
    endtask
    task automatic t_capture();
        u_cpu.wr16(6'h00, 16'h0100);
        u_cpu.wr16(6'h10, 16'h0300);
        cap_in(2'b11, 2'b11, 1'b0);
        u_cpu.rd16(6'h08, w);
        `CHK(w, 16'h0100);
        u_cpu.rd16(6'h18, w);
        `CHK(w, 16'h0300);
        cap_in(2'b00, 2'b00, 1'b0);
        cap_in(2'b00, 2'b11, 1'b0);
        `CHK(cap_cnt[0] + cap_cnt[1], 4);
        u_cpu.wr16(6'h00, 16'h01ff);
        cap_in(2'b00, 2'b00, 1'b0);
        u_cpu.rd(6'h08, b);
        `CHK(b, 8'hff);
        tick(2'b01);
        cap_in(2'b01, 2'b01, 1'b0);
        u_cpu.rd(6'h09, b);
        `CHK(b, 8'h01);
        u_cpu.wr16(6'h00, 16'h0234);
        @(posedge core_clk);
        capture_from_comparator <= 1'b1;
        cap_in(2'b01, 2'b00, 1'b1);
        `CHK(cap_cnt[0], 5);
        u_cpu.rd16(6'h08, w);
        `CHK(w, 16'h0234);
        @(posedge core_clk);
        top_from_capture <= 2'b01;
        tick(2'b01);
        `CHK(counter_value_t1, 16'h0000);
        cap_in(2'b01, 2'b00, 1'b0);
        cap_in(2'b01, 2'b00, 1'b1);
        `CHK(cap_cnt[0], 5);
        @(posedge core_clk);
        top_from_capture <= 2'b00;
        capture_from_comparator <= 1'b0;
        u_cpu.wr16(6'h18, 16'h0abc);
        u_cpu.rd16(6'h18, w);
        `CHK(w, 16'h0abc);
        $display("test capture done");
    endtask
    task automatic t_irq();
        for (int j = 0; j < 4; j++) begin
            u_cpu.wr(6'h20, 8'h04 << j);
            irq_in(1'b1, 4'hf);
            `CHK(timer1_irq_req, 4'h1 << j);
            u_cpu.rd(6'h20, b);
            `CHK(b, 8'h04 << j);
            irq_in(1'b1, 4'hf ^ (4'h1 << j));
            `CHK(timer1_irq_req, 4'h0);
            irq_in(1'b0, 4'hf);
            `CHK(timer1_irq_req, 4'h0);
        end
        $display("test irq done");
    endtask
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // hang guard, far beyond the few hundred cycles the run needs
    initial begin
        #2000000;
        err_count++;
        summarize();
    end
    initial begin
        rst_n = 1'b0;
        timer_tick = 2'b00;
        top_from_capture = 2'b00;
        capture_input_pin = 2'b00;
        capture_edge_polarity = 2'b00;
        capture_from_comparator = 1'b0;
        comparator_out = 1'b0;
        global_irq_enable = 1'b0;
        timer1_flags = 4'h0;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_reset();
        t_count();
        t_compare();
        t_capture();
        t_irq();
        summarize();
    end
endmodule
